// file: clk_sel_pkg.sv
// Constants, field layouts and state types for the clock select block
package clk_sel_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_OSC_CONFIG = 8'h1A;
  localparam logic [7:0] IDX_CLOCK_SELECT = 8'h09;
  localparam logic [7:0] IDX_OSC_CONTROL = 8'h1B;
  localparam logic [7:0] IDX_STATUS = 8'h1C;
  localparam logic [11:0] ADDR_OSC_CONFIG = {2'h0, IDX_OSC_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_CLOCK_SELECT = {2'h0, IDX_CLOCK_SELECT, 2'h0};
  localparam logic [11:0] ADDR_OSC_CONTROL = {2'h0, IDX_OSC_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  // Field positions of clock_select
  localparam int CS_PLL_SEL = 7;
  localparam int CS_PSEUDO = 6;
  localparam int CS_ACLK_DIS = 5;
  localparam int CS_WD_HI = 4;
  localparam int CS_RTI_PSTOP = 3;
  localparam int CS_WD_PSTOP = 2;
  localparam int CS_RTI_OSC = 1;
  localparam int CS_WD_LO = 0;
  // Field positions of osc_config and osc_control
  localparam int OC_EXT_OSC_EN = 7;
  localparam int CT_PROTECT = 4;
  localparam int CT_MON_RESET = 5;
  // Reset values
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h80;
  localparam logic [7:0] OSC_CONFIG_RESET = 8'h00;
  localparam logic [5:0] OSC_CONTROL_RESET = 6'h00;
  // Autonomous clock edges needed to enter stop with the watchdog on it and the autonomous clock disabled
  localparam logic [1:0] ACLK_STOP_LATENCY = 2'h2;
  // Bus clock is the selected source divided by this
  localparam logic [1:0] BUS_CLOCK_DIVIDE = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RUN,
    ENTERING,
    STOPPED
  } stop_state_t;

  typedef struct packed {
    logic awready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] clock_select;
    logic ext_osc_enable;
    logic [5:0] osc_control;
    logic osc_up_flag;
    logic pll_lock_flag;
    logic [2:0] stable_sync;
    logic [2:0] lock_sync;
    logic [2:0] loss_sync;
    logic [2:0] aclk_sync;
    stop_state_t stop_state;
    logic [1:0] aclk_count;
    logic pins_dedicated;
    logic mon_reset;
    logic wdog_restart;
    logic wdog_run;
    logic rti_run;
    logic osc_run;
    logic [1:0] wdog_src;
  } state_t;
endpackage

// file: clk_sel.sv
// Clock source selection, oscillator control and watchdog/timer stop gating
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module clk_sel (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic AWVALID_I,
  input wire logic [31:0] AWADDR_I,
  input wire logic [2:0] AWPROT_I,
  output logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  output logic WREADY_O,
  output logic BVALID_O,
  output logic [1:0] BRESP_O,
  input wire logic BREADY_I,
  input wire logic ARVALID_I,
  input wire logic [31:0] ARADDR_I,
  input wire logic [2:0] ARPROT_I,
  output logic ARREADY_O,
  output logic RVALID_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  input wire logic RREADY_I,
  input wire logic OSC_STABLE_I,
  input wire logic PLL_LOCKED_I,
  input wire logic OSC_LOSS_I,
  input wire logic ACLK_I,
  input wire logic STOP_REQ_I,
  input wire logic WAKE_I,
  output logic SYS_CLK_PLL_O,
  output logic OSC_ENABLE_O,
  output logic OSC_MONITOR_EN_O,
  output logic REF_FROM_OSC_O,
  output logic [3:0] REF_DIVIDER_O,
  output logic [1:0] WDOG_CLK_SRC_O,
  output logic WDOG_RUN_O,
  output logic WDOG_RESTART_O,
  output logic RTI_RUN_O,
  output logic IN_STOP_O,
  output logic OSC_MON_RESET_O,
  output logic CRYSTAL_PINS_DEDICATED_O
);

  clk_sel_pkg::state_t s;
  clk_sel_pkg::state_t next_s;

  logic [11:0] waddr;
  logic [11:0] raddr;
  logic wr_go;
  logic rd_go;
  logic osc_cfg_ok;
  logic stable_rise;
  logic lock_rise;
  logic loss_rise;
  logic aclk_tick;
  logic in_stop;
  logic pseudo;
  logic wd_lo_eff;
  logic rti_osc_eff;
  logic [7:0] cs_wr;
  logic [7:0] cs_new;
  logic [7:0] status;
  logic stop_entry;

  assign waddr = AWADDR_I[11:0];
  assign raddr = ARADDR_I[11:0];
  assign wr_go = s.awready & AWVALID_I & WVALID_I;
  assign rd_go = s.arready & ARVALID_I;
  assign stable_rise = s.stable_sync[1] & ~s.stable_sync[2];
  assign lock_rise = s.lock_sync[1] & ~s.lock_sync[2];
  assign loss_rise = s.loss_sync[1] & ~s.loss_sync[2];
  assign aclk_tick = s.aclk_sync[1] & ~s.aclk_sync[2];
  assign in_stop = (s.stop_state == clk_sel_pkg::STOPPED);
  assign pseudo = s.clock_select[clk_sel_pkg::CS_PSEUDO];
  // Oscillator sources count only once oscillation is stable
  assign wd_lo_eff = s.clock_select[clk_sel_pkg::CS_WD_LO] & s.osc_up_flag;
  assign rti_osc_eff = s.clock_select[clk_sel_pkg::CS_RTI_OSC] & s.osc_up_flag;
  // Oscillator config writes pass only when unprotected with PLL selected
  assign osc_cfg_ok = ~s.osc_control[clk_sel_pkg::CT_PROTECT]
                      & s.clock_select[clk_sel_pkg::CS_PLL_SEL];
  assign status = {4'h0, s.pins_dedicated, in_stop, s.pll_lock_flag, s.osc_up_flag};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_s = s;
    cs_wr = WDATA_I[7:0];
    cs_new = s.clock_select;
    // Synchronisers for pins and the autonomous clock
    next_s.stable_sync = {s.stable_sync[1:0], OSC_STABLE_I};
    next_s.lock_sync = {s.lock_sync[1:0], PLL_LOCKED_I};
    next_s.loss_sync = {s.loss_sync[1:0], OSC_LOSS_I};
    next_s.aclk_sync = {s.aclk_sync[1:0], ACLK_I};

    // Write channel: address and data taken together, one write at a time
    next_s.awready = AWVALID_I & WVALID_I & ~s.awready & ~s.bvalid;
    if (s.bvalid && BREADY_I) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = clk_sel_pkg::RESP_OKAY;
      if (waddr == clk_sel_pkg::ADDR_OSC_CONFIG) begin
        if (WSTRB_I[0] && osc_cfg_ok) begin
          next_s.ext_osc_enable = WDATA_I[clk_sel_pkg::OC_EXT_OSC_EN];
          next_s.osc_up_flag = 1'b0;
          next_s.pll_lock_flag = 1'b0;
        end
      end else if (waddr == clk_sel_pkg::ADDR_CLOCK_SELECT) begin
        if (WSTRB_I[0]) begin
          cs_new = cs_wr;
          // Clearing the PLL select needs a running oscillator
          if (!s.osc_up_flag) begin
            cs_new[clk_sel_pkg::CS_PLL_SEL] = 1'b1;
          end
        end
      end else if (waddr == clk_sel_pkg::ADDR_OSC_CONTROL) begin
        if (WSTRB_I[0]) begin
          next_s.osc_control = WDATA_I[5:0];
        end
      end else if (waddr == clk_sel_pkg::ADDR_STATUS) begin
        next_s.bresp = clk_sel_pkg::RESP_OKAY;
      end else begin
        next_s.bresp = clk_sel_pkg::RESP_SLVERR;
      end
    end

    // Read channel: answer one cycle after the address is taken
    next_s.arready = ARVALID_I & ~s.arready & ~s.rvalid;
    if (s.rvalid && RREADY_I) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = clk_sel_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (raddr == clk_sel_pkg::ADDR_OSC_CONFIG) begin
        next_s.rdata[clk_sel_pkg::OC_EXT_OSC_EN] = s.ext_osc_enable;
      end else if (raddr == clk_sel_pkg::ADDR_CLOCK_SELECT) begin
        next_s.rdata[7:0] = s.clock_select;
      end else if (raddr == clk_sel_pkg::ADDR_OSC_CONTROL) begin
        next_s.rdata[5:0] = s.osc_control;
      end else if (raddr == clk_sel_pkg::ADDR_STATUS) begin
        next_s.rdata[7:0] = status;
      end else begin
        next_s.rresp = clk_sel_pkg::RESP_SLVERR;
      end
    end

    // Status flags: a new stable or lock event wins over a clearing write
    if (stable_rise && s.ext_osc_enable) begin
      next_s.osc_up_flag = 1'b1;
    end
    if (!s.stable_sync[1] || !s.ext_osc_enable) begin
      next_s.osc_up_flag = 1'b0;
    end
    if (lock_rise) begin
      next_s.pll_lock_flag = 1'b1;
    end
    if (!s.lock_sync[1]) begin
      next_s.pll_lock_flag = 1'b0;
    end

    // Crystal pins belong to the oscillator until reset once enabled
    if (next_s.ext_osc_enable) begin
      next_s.pins_dedicated = 1'b1;
    end

    // Stop sequencing
    case (s.stop_state)
      clk_sel_pkg::RUN: begin
        next_s.aclk_count = 2'h0;
        if (STOP_REQ_I) begin
          if (s.clock_select[clk_sel_pkg::CS_ACLK_DIS]
              && s.clock_select[clk_sel_pkg::CS_WD_HI]) begin
            next_s.stop_state = clk_sel_pkg::ENTERING;
          end else begin
            next_s.stop_state = clk_sel_pkg::STOPPED;
          end
        end
      end
      clk_sel_pkg::ENTERING: begin
        // Wait for the autonomous clock to see the request
        if (aclk_tick) begin
          next_s.aclk_count = s.aclk_count + 2'h1;
          if (s.aclk_count + 2'h1 == clk_sel_pkg::ACLK_STOP_LATENCY) begin
            next_s.stop_state = clk_sel_pkg::STOPPED;
          end
        end
      end
      clk_sel_pkg::STOPPED: begin
        if (WAKE_I) begin
          next_s.stop_state = clk_sel_pkg::RUN;
        end
      end
      default: begin
        next_s.stop_state = clk_sel_pkg::RUN;
      end
    endcase
    // Entry into the stopped state, known here so no loop runs through the struct
    stop_entry = (next_s.stop_state == clk_sel_pkg::STOPPED) && !in_stop;

    // Full stop or a lost oscillator puts the system back on the PLL
    if ((stop_entry && !cs_new[clk_sel_pkg::CS_PSEUDO]) || !next_s.osc_up_flag) begin
      cs_new[clk_sel_pkg::CS_PLL_SEL] = 1'b1;
    end
    next_s.clock_select = cs_new;

    // Watchdog restart on source change; low select ignored behind high
    next_s.wdog_restart = (cs_new[clk_sel_pkg::CS_WD_HI]
                           != s.clock_select[clk_sel_pkg::CS_WD_HI])
                          | (~cs_new[clk_sel_pkg::CS_WD_HI]
                             & ~s.clock_select[clk_sel_pkg::CS_WD_HI]
                             & (cs_new[clk_sel_pkg::CS_WD_LO]
                                != s.clock_select[clk_sel_pkg::CS_WD_LO]));
    // Watchdog source: 2 autonomous, 1 oscillator, 0 internal RC
    if (cs_new[clk_sel_pkg::CS_WD_HI]) begin
      next_s.wdog_src = 2'h2;
    end else begin
      next_s.wdog_src = {1'b0, cs_new[clk_sel_pkg::CS_WD_LO] & next_s.osc_up_flag};
    end

    // Run enables while stopped; halted counters keep their value
    if (next_s.stop_state == clk_sel_pkg::STOPPED) begin
      if (cs_new[clk_sel_pkg::CS_WD_HI]) begin
        next_s.wdog_run = ~cs_new[clk_sel_pkg::CS_ACLK_DIS];
      end else begin
        next_s.wdog_run = cs_new[clk_sel_pkg::CS_PSEUDO] & cs_new[clk_sel_pkg::CS_WD_PSTOP]
                          & wd_lo_eff;
      end
      next_s.rti_run = cs_new[clk_sel_pkg::CS_PSEUDO] & cs_new[clk_sel_pkg::CS_RTI_PSTOP]
                       & rti_osc_eff;
      next_s.osc_run = next_s.ext_osc_enable & cs_new[clk_sel_pkg::CS_PSEUDO];
    end else begin
      next_s.wdog_run = 1'b1;
      next_s.rti_run = 1'b1;
      next_s.osc_run = next_s.ext_osc_enable;
    end

    // Loss of oscillation raises a monitor reset when armed
    next_s.mon_reset = loss_rise & s.ext_osc_enable
                       & s.osc_control[clk_sel_pkg::CT_MON_RESET];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      s <= '0;
      s.clock_select <= clk_sel_pkg::CLOCK_SELECT_RESET;
      s.ext_osc_enable <= clk_sel_pkg::OSC_CONFIG_RESET[clk_sel_pkg::OC_EXT_OSC_EN];
      s.osc_control <= clk_sel_pkg::OSC_CONTROL_RESET;
      s.stop_state <= clk_sel_pkg::RUN;
      s.wdog_run <= 1'b1;
      s.rti_run <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register
  assign AWREADY_O = s.awready;
  assign WREADY_O = s.awready;
  assign BVALID_O = s.bvalid;
  assign BRESP_O = s.bresp;
  assign ARREADY_O = s.arready;
  assign RVALID_O = s.rvalid;
  assign RDATA_O = s.rdata;
  assign RRESP_O = s.rresp;
  // Clock mux select; bus clock divider is fixed at two
  assign SYS_CLK_PLL_O = s.clock_select[clk_sel_pkg::CS_PLL_SEL];
  assign OSC_ENABLE_O = s.osc_run;
  assign OSC_MONITOR_EN_O = s.ext_osc_enable;
  assign REF_FROM_OSC_O = s.ext_osc_enable;
  assign REF_DIVIDER_O = s.osc_control[3:0];
  assign WDOG_CLK_SRC_O = s.wdog_src;
  assign WDOG_RUN_O = s.wdog_run;
  assign WDOG_RESTART_O = s.wdog_restart;
  assign RTI_RUN_O = s.rti_run;
  assign IN_STOP_O = in_stop;
  assign OSC_MON_RESET_O = s.mon_reset;
  assign CRYSTAL_PINS_DEDICATED_O = s.pins_dedicated;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  a_pll_clear_guard: assert property (
    !SYS_CLK_PLL_O && $past(SYS_CLK_PLL_O) |-> $past(s.osc_up_flag))
    else $error("PLL select cleared without stable oscillator");
  a_pll_forced_up: assert property (
    !s.osc_up_flag |=> SYS_CLK_PLL_O)
    else $error("PLL select not forced while oscillator down");
  a_full_stop_pll: assert property (
    $rose(IN_STOP_O) && !s.clock_select[clk_sel_pkg::CS_PSEUDO] |-> SYS_CLK_PLL_O)
    else $error("Full stop entered without PLL select");
  a_osc_off_stop: assert property (
    IN_STOP_O && !s.clock_select[clk_sel_pkg::CS_PSEUDO] |-> !OSC_ENABLE_O)
    else $error("Oscillator running in full stop");
  a_aclk_latency: assert property (
    $rose(IN_STOP_O) && $past(s.stop_state) == clk_sel_pkg::ENTERING
    |-> $past(s.aclk_count) == 2'h1)
    else $error("Stop entered before two autonomous clock edges");
  a_wdog_frozen: assert property (
    IN_STOP_O && $past(IN_STOP_O) && s.clock_select[clk_sel_pkg::CS_WD_HI]
    && s.clock_select[clk_sel_pkg::CS_ACLK_DIS] && $stable(s.clock_select) |-> !WDOG_RUN_O)
    else $error("Watchdog ran in stop with autonomous clock disabled");
  a_wd_hi_restart: assert property (
    $changed(s.clock_select[clk_sel_pkg::CS_WD_HI]) |-> WDOG_RESTART_O)
    else $error("Watchdog not restarted on source change");
  a_wd_lo_quiet: assert property (
    s.clock_select[clk_sel_pkg::CS_WD_HI] && $past(s.clock_select[clk_sel_pkg::CS_WD_HI])
    |-> !WDOG_RESTART_O && WDOG_CLK_SRC_O == 2'h2)
    else $error("Low select acted while high select set");
  a_osc_write_gate: assert property (
    $changed(s.ext_osc_enable) && s.ext_osc_enable |-> $past(wr_go && osc_cfg_ok))
    else $error("Oscillator config changed by a blocked write");
  a_flags_cleared: assert property (
    wr_go && osc_cfg_ok && WSTRB_I[0] && waddr == clk_sel_pkg::ADDR_OSC_CONFIG
    && !stable_rise |=> !s.osc_up_flag)
    else $error("Accepted oscillator write left up flag set");
  a_pins_sticky: assert property (
    CRYSTAL_PINS_DEDICATED_O |=> CRYSTAL_PINS_DEDICATED_O)
    else $error("Crystal pins released before reset");
  a_monitor_reset: assert property (
    loss_rise && s.ext_osc_enable && s.osc_control[clk_sel_pkg::CT_MON_RESET]
    |=> OSC_MON_RESET_O)
    else $error("Loss of oscillation gave no monitor reset");
  a_lo_kept: assert property (
    $fell(s.osc_up_flag) && !$past(wr_go) |-> $stable(s.clock_select[clk_sel_pkg::CS_WD_LO]))
    else $error("Low watchdog select lost when oscillator went down");
  a_rti_halted: assert property (
    IN_STOP_O && !(s.clock_select[clk_sel_pkg::CS_PSEUDO]
    && s.clock_select[clk_sel_pkg::CS_RTI_PSTOP]) |-> !RTI_RUN_O)
    else $error("Periodic timer ran in stop without its enable");
  a_wdog_osc_src: assert property (
    WDOG_CLK_SRC_O == 2'h1 |-> s.osc_up_flag)
    else $error("Watchdog on oscillator before oscillation stable");

  // Cover points for the main scenarios
  c_pseudo_stop: cover property ($rose(IN_STOP_O) && s.clock_select[clk_sel_pkg::CS_PSEUDO]);
  c_entering: cover property (s.stop_state == clk_sel_pkg::ENTERING ##[1:40] IN_STOP_O);
  c_osc_system: cover property (!SYS_CLK_PLL_O);
  c_blocked_write: cover property (wr_go && !osc_cfg_ok);
  c_mon_reset: cover property (OSC_MON_RESET_O);

endmodule

// file: crystal_model.sv
// Behavioural external crystal oscillator, lock source and free-running autonomous clock
`timescale 1ns/100ps
module crystal_model #(
  parameter int STARTUP_CYCLES = 20,
  parameter int ACLK_HALF_NS = 37
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic lose_i,
  output logic stable_o,
  output logic locked_o,
  output logic loss_o,
  output logic aclk_o
);
  int up_count;

  // Oscillation settles a fixed time after enable; dies at once when disabled or lost
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_count <= 0;
      stable_o <= 1'b0;
    end else if (!enable_i || lose_i) begin
      up_count <= 0;
      stable_o <= 1'b0;
    end else if (up_count < STARTUP_CYCLES) begin
      up_count <= up_count + 1;
    end else begin
      stable_o <= 1'b1;
    end
  end

  // Lock follows stable oscillation; loss is seen only while the oscillator is enabled
  assign locked_o = stable_o;
  assign loss_o = enable_i & lose_i;

  // Autonomous RC clock runs free, unrelated in phase to the system clock
  initial begin
    aclk_o = 1'b0;
    forever #(ACLK_HALF_NS) aclk_o = ~aclk_o;
  end
endmodule

// file: tb.sv
// Self-checking bench for the clock select block
`timescale 1ns/100ps
module tb;
  logic clk, rst, awv, wv, brdy, arv, rrdy, stop_req, wake, lose, s;
  logic [31:0] awa, wd, ara, rdata, v;
  logic [3:0] wst, rdiv;
  logic [1:0] bresp, rresp, wsrc, r;
  logic awr, wrdy, bv, arr, rv, pll, osc_en, mon_en, ref_osc, wrun, wrst, rrun, istop, mrst;
  logic pins, stable, locked, loss, aclk;
  int errors = 0;
  int tests_run = 0;
  int restarts = 0;
  int mresets = 0;
  int r0;

  always #5 clk = ~clk;

  clk_sel dut_u (.CLOCK_I(clk), .RST_I(rst), .AWVALID_I(awv), .AWADDR_I(awa), .AWPROT_I(3'h0),
    .AWREADY_O(awr), .WVALID_I(wv), .WDATA_I(wd), .WSTRB_I(wst), .WREADY_O(wrdy),
    .BVALID_O(bv), .BRESP_O(bresp), .BREADY_I(brdy), .ARVALID_I(arv), .ARADDR_I(ara),
    .ARPROT_I(3'h0), .ARREADY_O(arr), .RVALID_O(rv), .RDATA_O(rdata), .RRESP_O(rresp),
    .RREADY_I(rrdy), .OSC_STABLE_I(stable), .PLL_LOCKED_I(locked), .OSC_LOSS_I(loss),
    .ACLK_I(aclk), .STOP_REQ_I(stop_req), .WAKE_I(wake), .SYS_CLK_PLL_O(pll),
    .OSC_ENABLE_O(osc_en), .OSC_MONITOR_EN_O(mon_en), .REF_FROM_OSC_O(ref_osc),
    .REF_DIVIDER_O(rdiv), .WDOG_CLK_SRC_O(wsrc), .WDOG_RUN_O(wrun), .WDOG_RESTART_O(wrst),
    .RTI_RUN_O(rrun), .IN_STOP_O(istop), .OSC_MON_RESET_O(mrst),
    .CRYSTAL_PINS_DEDICATED_O(pins));

  crystal_model osc_u (.clk_i(clk), .rst_i(rst), .enable_i(osc_en), .lose_i(lose),
    .stable_o(stable), .locked_o(locked), .loss_o(loss), .aclk_o(aclk));

  // Count watchdog restart and monitor reset pulses
  always @(posedge clk) begin
    if (wrst === 1'b1) restarts++;
    if (mrst === 1'b1) mresets++;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // Write one byte; address and data released as each is taken
  task wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= {20'h00000, a};
    wd <= {24'h000000, d};
    brdy <= 1'b1;
    while ((awv || wv) && n < 50) begin
      @(posedge clk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end
    while (bv !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    r = bresp;
    brdy <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  // Read one word; data and response taken at the handshake edge
  task rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= {20'h00000, a};
    rrdy <= 1'b1;
    while (arv && n < 50) begin
      @(posedge clk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end
    while (rv !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    v = rdata;
    r = rresp;
    rrdy <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  // Pulse a stop request; report the stop state one cycle later, then wait for it
  task stp;
    int n;
    n = 0;
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    #1;
    s = istop;
    while (istop !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task wk;
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Poll status until the oscillator reports stable
  task wait_up;
    int n;
    n = 0;
    v = 32'h0;
    while (v[0] !== 1'b1 && n < 40) begin
      rd(clk_sel_pkg::ADDR_STATUS);
      n++;
    end
  endtask

  task results;
    $display("Checks run %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results;
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awv, wv, brdy, arv, rrdy, stop_req, wake, lose} = 8'h00;
    awa = 32'h0;
    ara = 32'h0;
    wd = 32'h0;
    wst = 4'hF;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(clk_sel_pkg::ADDR_CLOCK_SELECT);
    chk(v, 32'h80);
    chk(32'(pll), 32'h1);
    rd(clk_sel_pkg::ADDR_OSC_CONFIG);
    chk(v, 32'h0);
    rd(12'hFF0);
    chk({v[29:0], r}, {30'h0, clk_sel_pkg::RESP_SLVERR});
    wr(12'hFF0, 8'hFF);
    chk(32'(r), 32'(clk_sel_pkg::RESP_SLVERR));
    // Oscillator not up: selects refused or kept
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h00);
    rd(clk_sel_pkg::ADDR_CLOCK_SELECT);
    chk(v, 32'h80);
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h10);
    rd(clk_sel_pkg::ADDR_CLOCK_SELECT);
    chk(v, 32'h90);
    chk(32'(wsrc), 32'h2);
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h00);
    // Protected write ignored, then enable oscillator
    wr(clk_sel_pkg::ADDR_OSC_CONTROL, 8'h10);
    wr(clk_sel_pkg::ADDR_OSC_CONFIG, 8'h80);
    rd(clk_sel_pkg::ADDR_OSC_CONFIG);
    chk(v, 32'h0);
    wr(clk_sel_pkg::ADDR_OSC_CONTROL, 8'h05);
    chk(32'(rdiv), 32'h5);
    wr(clk_sel_pkg::ADDR_OSC_CONFIG, 8'h80);
    chk(32'({osc_en, mon_en, ref_osc, pins}), 32'hF);
    rd(clk_sel_pkg::ADDR_STATUS);
    chk(32'(v[0]), 32'h0);
    wait_up;
    chk(32'(v[0]), 32'h1);
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h00);
    rd(clk_sel_pkg::ADDR_CLOCK_SELECT);
    chk(v, 32'h0);
    chk(32'(pll), 32'h0);
    wr(clk_sel_pkg::ADDR_OSC_CONFIG, 8'h00);
    rd(clk_sel_pkg::ADDR_OSC_CONFIG);
    chk(v, 32'h80);
    // Full stop forces PLL and stops the oscillator
    stp;
    chk(32'({s, osc_en}), 32'h2);
    wk;
    chk(32'(pll), 32'h1);
    wait_up;
    wr(clk_sel_pkg::ADDR_OSC_CONFIG, 8'h80);
    rd(clk_sel_pkg::ADDR_STATUS);
    chk(32'(v[1:0]), 32'h0);
    wr(clk_sel_pkg::ADDR_OSC_CONFIG, 8'h00);
    wr(clk_sel_pkg::ADDR_OSC_CONFIG, 8'h80);
    wait_up;
    // Watchdog source selection and restarts
    r0 = restarts;
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h10);
    repeat (3) @(posedge clk);
    chk(32'(restarts - r0), 32'h1);
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h11);
    repeat (3) @(posedge clk);
    chk(32'({restarts - r0, wsrc}), 32'h6);
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h01);
    repeat (3) @(posedge clk);
    chk(32'({restarts - r0, wsrc}), 32'h9);
    // Pseudo stop with timer and watchdog enabled, then disabled
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h4F);
    stp;
    chk(32'({osc_en, wrun, rrun}), 32'h7);
    wk;
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h40);
    stp;
    chk(32'({osc_en, wrun, rrun}), 32'h4);
    wk;
    chk(32'({wrun, rrun}), 32'h3);
    // Watchdog on autonomous clock, gated in stop only with the autonomous clock disabled
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h70);
    stp;
    chk(32'({s, wrun}), 32'h0);
    wk;
    chk(32'(wrun), 32'h1);
    repeat (20) @(posedge clk);
    wr(clk_sel_pkg::ADDR_CLOCK_SELECT, 8'h50);
    stp;
    chk(32'({s, wrun}), 32'h3);
    wk;
    chk(32'(pll), 32'h0);
    // Loss of oscillation with monitor reset enabled
    wr(clk_sel_pkg::ADDR_OSC_CONTROL, 8'h20);
    lose <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'({mresets, pll}), 32'h3);
    lose <= 1'b0;
    wr(clk_sel_pkg::ADDR_OSC_CONFIG, 8'h00);
    chk(32'({osc_en, pins}), 32'h1);
    results;
  end
endmodule
